// *** serial_port_pkg.sv ***
// Constants and carrier types for the timer-driven serial port
package serial_port_pkg;

    // Register addresses on the plain register port
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_DATA    = 2'h1;
    localparam logic [1:0] ADDR_RELOAD  = 2'h2;
    localparam logic [1:0] ADDR_TIMER   = 2'h3;

    // Serial control register field positions
    localparam int BIT_MODE     = 7;
    localparam int BIT_UNUSED   = 6;
    localparam int BIT_MPE      = 5;
    localparam int BIT_RXEN     = 4;
    localparam int BIT_TX9      = 3;
    localparam int BIT_RX9      = 2;
    localparam int BIT_TXDONE   = 1;
    localparam int BIT_RXDONE   = 0;

    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h40;
    localparam logic [7:0] BYTE_RESET    = 8'h00;

    // Timer clock source select, and divider figures
    localparam logic [2:0] SRC_SYS      = 3'h0;
    localparam logic [2:0] SRC_DIV4     = 3'h1;
    localparam logic [2:0] SRC_DIV12    = 3'h2;
    localparam logic [2:0] SRC_DIV48    = 3'h3;
    localparam logic [2:0] SRC_EXT_OSC  = 3'h4;
    localparam logic [2:0] SRC_EXT_PIN  = 3'h5;
    localparam logic [5:0] PRESCALE_MAX = 6'h2F;
    localparam int         DIV4_N       = 4;
    localparam int         DIV12_N      = 12;
    localparam int         DIV48_N      = 48;
    localparam logic [2:0] EXT_OSC_LAST = 3'h7;
    localparam logic [7:0] TIMER_TOP    = 8'hFF;

    // Frame lengths in bits after the start bit
    localparam logic [3:0] DATA_BITS    = 4'h8;
    localparam logic [3:0] FRAME8_LAST  = 4'h9;
    localparam logic [3:0] FRAME9_LAST  = 4'hA;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic       mode9;
        logic       mpe;
        logic       rx_en;
        logic       tx9;
    } ctrl_t;

endpackage : serial_port_pkg

// *** serial_port_zero.sv ***
// Asynchronous serial port with timer-derived bit rate
`timescale 1ns/100ps

// Summary of operation
// - Data writes load transmit register; data reads return receive latch only.
// - Done flags stay set until software writes them clear.
// - Transmit timing from timer low byte overflow; receive from hidden copy.
// - Each overflow stream is halved to make its bit clock.
// - Timer overflows every 256 minus reload ticks; bit rate is half.
// - Receive timer runs with timer, same reload, reloaded on start bit.
// - Timer clock chosen from six sources.
// - Control bit 7 chooses 8-bit or 9-bit frames.
// - 8-bit frame: start, eight data bits LSB first, stop.
// - 8-bit mode stores data byte, and stop bit in control bit 2.
// - Writing the data buffer starts a transmit frame.
// - Transmit done flag sets at start of stop bit.
// - Reception starts only while receive enable bit 4 is one; a frame under way completes.
// - 8-bit load needs receive flag clear and, with filter, stop one.
// - Load stores byte, ninth bit, sets flag; otherwise nothing changes.
// - Overrun keeps the first byte and drops later data.
// - Interrupt request asserts while enabled and either done flag set.
// - 9-bit frame: start, eight data LSB first, ninth bit, stop.
// - Transmitted ninth bit comes from control bit 3.
// - 9-bit mode stores ninth bit; stop level ignored.
// - 9-bit load with filter needs ninth bit one; flag must be clear.
// - Receive shifter is separate from the receive latch.
// - Mode bit zero means 8-bit, one means 9-bit frames.
// - Multiprocessor enable sits at control bit 5.
// - Receive flag sets when the stop bit is sampled.
module serial_port_zero
    import serial_port_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Register port
    input  wire reg_req_t   req,
    output logic [7:0]      rdata,
    // Timer control
    input  wire logic       timer_run,
    input  wire logic [2:0] timer_src,
    input  wire logic       ext_osc_clk,
    input  wire logic       aux_timer_ext_input,
    input  wire logic       irq_enable,
    // Serial pins and interrupt
    input  wire logic       rx_pin,
    output logic            tx_pin,
    output logic            irq
);

    // ************************************************************
    // Register storage
    // ************************************************************
    ctrl_t       ctrl_r;
    logic        tx_done_flag_r;
    logic        rx_done_flag_r;
    logic        rx_ninth_bit_r;
    logic [7:0]  rx_latch_r;
    logic [7:0]  aux_timer_reload_byte_r;
    logic [7:0]  aux_timer_low_byte_r;
    logic        wr_ctrl;
    logic        wr_data;
    logic        tx_done_set;
    logic        rx_load;
    logic [7:0]  ctrl_rd;

    assign wr_ctrl = req.wr && (req.addr == ADDR_CONTROL);
    assign wr_data = req.wr && (req.addr == ADDR_DATA);

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ctrl_r <= '0;
        end
        else if (wr_ctrl)
        begin
            ctrl_r.mode9 <= req.wdata[BIT_MODE];
            ctrl_r.mpe   <= req.wdata[BIT_MPE];
            ctrl_r.rx_en <= req.wdata[BIT_RXEN];
            ctrl_r.tx9   <= req.wdata[BIT_TX9];
        end
    end

    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            tx_done_flag_r <= 1'b0;
        else if (tx_done_set)
            tx_done_flag_r <= 1'b1;
        else if (wr_ctrl)
            tx_done_flag_r <= req.wdata[BIT_TXDONE];
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            rx_done_flag_r <= 1'b0;
        else if (rx_load)
            rx_done_flag_r <= 1'b1;
        else if (wr_ctrl)
            rx_done_flag_r <= req.wdata[BIT_RXDONE];
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            aux_timer_reload_byte_r <= BYTE_RESET;
        else if (req.wr && (req.addr == ADDR_RELOAD))
            aux_timer_reload_byte_r <= req.wdata;
    end

    always_comb
    begin
        ctrl_rd               = CONTROL_RESET;
        ctrl_rd[BIT_MODE]     = ctrl_r.mode9;
        ctrl_rd[BIT_MPE]      = ctrl_r.mpe;
        ctrl_rd[BIT_RXEN]     = ctrl_r.rx_en;
        ctrl_rd[BIT_TX9]      = ctrl_r.tx9;
        ctrl_rd[BIT_RX9]      = rx_ninth_bit_r;
        ctrl_rd[BIT_TXDONE]   = tx_done_flag_r;
        ctrl_rd[BIT_RXDONE]   = rx_done_flag_r;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            rdata <= BYTE_RESET;
        else if (req.rd)
        begin
            unique case (req.addr)
                ADDR_CONTROL: rdata <= ctrl_rd;
                ADDR_DATA:    rdata <= rx_latch_r;
                ADDR_RELOAD:  rdata <= aux_timer_reload_byte_r;
                ADDR_TIMER:   rdata <= aux_timer_low_byte_r;
            endcase
        end
        else
            rdata <= BYTE_RESET;
    end

    assign irq = irq_enable && (tx_done_flag_r || rx_done_flag_r);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [2:0] rx_sync_r;
    logic [2:0] xin_sync_r;
    logic [2:0] osc_sync_r;
    logic       rx_level_r;
    logic       xin_level_r;
    logic       osc_level_r;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rx_sync_r  <= 3'h7;
            xin_sync_r <= 3'h0;
            osc_sync_r <= 3'h0;
        end
        else
        begin
            rx_sync_r  <= {rx_sync_r[1:0], rx_pin};
            xin_sync_r <= {xin_sync_r[1:0], aux_timer_ext_input};
            osc_sync_r <= {osc_sync_r[1:0], ext_osc_clk};
        end
    end

    // Level changes only once stages two and three agree
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rx_level_r  <= 1'b1;
            xin_level_r <= 1'b0;
            osc_level_r <= 1'b0;
        end
        else
        begin
            if (rx_sync_r[1] == rx_sync_r[2])
                rx_level_r <= rx_sync_r[2];
            if (xin_sync_r[1] == xin_sync_r[2])
                xin_level_r <= xin_sync_r[2];
            if (osc_sync_r[1] == osc_sync_r[2])
                osc_level_r <= osc_sync_r[2];
        end
    end

    // ************************************************************
    // Timer clock source and timers
    // ************************************************************
    logic [5:0] pre_cnt_r;
    logic [2:0] osc_cnt_r;
    logic       xin_prev_r;
    logic       osc_prev_r;
    logic       tick;
    logic       tx_ovf;
    logic       rx_ovf;
    logic [7:0] rx_timer_r;
    logic       rx_reload;

    function automatic logic pre_hit(input logic [5:0] cnt, input int n);
        pre_hit = (int'(cnt) % n) == (n - 1);
    endfunction

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            pre_cnt_r  <= '0;
            osc_cnt_r  <= '0;
            xin_prev_r <= 1'b0;
            osc_prev_r <= 1'b0;
        end
        else
        begin
            pre_cnt_r  <= (pre_cnt_r == PRESCALE_MAX) ? '0 : pre_cnt_r + 6'h01;
            xin_prev_r <= xin_level_r;
            osc_prev_r <= osc_level_r;
            if (osc_level_r && !osc_prev_r)
                osc_cnt_r <= osc_cnt_r + 3'h1;
        end
    end

    always_comb
    begin
        unique case (timer_src)
            SRC_SYS:     tick = 1'b1;
            SRC_DIV4:    tick = pre_hit(pre_cnt_r, DIV4_N);
            SRC_DIV12:   tick = pre_hit(pre_cnt_r, DIV12_N);
            SRC_DIV48:   tick = pre_hit(pre_cnt_r, DIV48_N);
            SRC_EXT_OSC: tick = osc_level_r && !osc_prev_r && (osc_cnt_r == EXT_OSC_LAST);
            SRC_EXT_PIN: tick = xin_level_r && !xin_prev_r;
            default:     tick = 1'b0;
        endcase
    end

    assign tx_ovf = timer_run && tick && (aux_timer_low_byte_r == TIMER_TOP);
    assign rx_ovf = timer_run && tick && (rx_timer_r == TIMER_TOP);

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            aux_timer_low_byte_r <= BYTE_RESET;
        else if (req.wr && (req.addr == ADDR_TIMER))
            aux_timer_low_byte_r <= req.wdata;
        else if (tx_ovf)
            aux_timer_low_byte_r <= aux_timer_reload_byte_r;
        else if (timer_run && tick)
            aux_timer_low_byte_r <= aux_timer_low_byte_r + 8'h01;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            rx_timer_r <= BYTE_RESET;
        else if (rx_reload || rx_ovf)
            rx_timer_r <= aux_timer_reload_byte_r;
        else if (timer_run && tick)
            rx_timer_r <= rx_timer_r + 8'h01;
    end

    // ************************************************************
    // Transmitter
    // ************************************************************
    typedef enum {TX_IDLE, TX_START, TX_BITS} tx_state_t;
    tx_state_t   tx_state_r;
    logic        tx_half_r;
    logic [3:0]  tx_idx_r;
    logic [8:0]  tx_shift_r;
    logic        tx_bit_tick;
    logic [3:0]  tx_last;

    assign tx_bit_tick = tx_ovf && tx_half_r;
    assign tx_last     = ctrl_r.mode9 ? FRAME9_LAST : FRAME8_LAST;
    assign tx_done_set = tx_bit_tick && (tx_state_r == TX_BITS) && (tx_idx_r == tx_last - 4'h1);

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            tx_half_r <= 1'b0;
        else if (tx_ovf)
            tx_half_r <= !tx_half_r;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            tx_state_r <= TX_IDLE;
            tx_idx_r   <= '0;
            tx_shift_r <= '0;
            tx_pin     <= 1'b1;
        end
        else
        begin
            unique case (tx_state_r)
                TX_IDLE:
                    if (wr_data)
                    begin
                        tx_shift_r <= {ctrl_r.tx9, req.wdata};
                        tx_state_r <= TX_START;
                    end
                TX_START:
                    if (tx_bit_tick)
                    begin
                        tx_pin     <= 1'b0;
                        tx_idx_r   <= '0;
                        tx_state_r <= TX_BITS;
                    end
                TX_BITS:
                    if (tx_bit_tick)
                    begin
                        if (tx_idx_r == tx_last)
                        begin
                            tx_state_r <= TX_IDLE;
                        end
                        else if (tx_idx_r == tx_last - 4'h1)
                        begin
                            tx_pin   <= 1'b1;                    // Stop bit
                            tx_idx_r <= tx_idx_r + 4'h1;
                        end
                        else
                        begin
                            tx_pin     <= tx_shift_r[0];
                            tx_shift_r <= {1'b0, tx_shift_r[8:1]};
                            tx_idx_r   <= tx_idx_r + 4'h1;
                        end
                    end
            endcase
        end
    end

    // ************************************************************
    // Receiver
    // ************************************************************
    typedef enum {RX_IDLE, RX_START, RX_BITS} rx_state_t;
    rx_state_t   rx_state_r;
    logic        rx_half_r;
    logic [3:0]  rx_idx_r;
    logic [8:0]  rx_shift_r;
    logic [3:0]  rx_last;
    logic        rx_ninth;
    logic        rx_ok;

    assign rx_reload = (rx_state_r == RX_IDLE) && ctrl_r.rx_en && !rx_level_r;
    assign rx_last   = ctrl_r.mode9 ? FRAME9_LAST : FRAME8_LAST;
    // In 8-bit mode the ninth stored bit is the stop bit
    assign rx_ninth  = ctrl_r.mode9 ? rx_shift_r[8] : rx_level_r;
    assign rx_ok     = !rx_done_flag_r && (!ctrl_r.mpe || rx_ninth);
    assign rx_load   = rx_ovf && !rx_half_r && (rx_state_r == RX_BITS)
                       && (rx_idx_r == rx_last - 4'h1) && rx_ok;

    // Half-period phase puts every sample at mid-bit
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || rx_reload)
            rx_half_r <= 1'b0;
        else if (rx_ovf)
            rx_half_r <= !rx_half_r;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rx_state_r <= RX_IDLE;
            rx_idx_r   <= '0;
            rx_shift_r <= '0;
        end
        else
        begin
            unique case (rx_state_r)
                RX_IDLE:
                    if (rx_reload)
                        rx_state_r <= RX_START;
                RX_START:
                    if (rx_ovf && !rx_half_r)
                    begin
                        rx_idx_r   <= '0;
                        rx_state_r <= rx_level_r ? RX_IDLE : RX_BITS;
                    end
                RX_BITS:
                    if (rx_ovf && !rx_half_r)
                    begin
                        if (rx_idx_r == rx_last - 4'h1)
                            rx_state_r <= RX_IDLE;
                        else
                        begin
                            if (rx_idx_r < DATA_BITS)
                                rx_shift_r <= {1'b0, rx_level_r, rx_shift_r[7:1]};
                            else
                                rx_shift_r[8] <= rx_level_r;
                            rx_idx_r <= rx_idx_r + 4'h1;
                        end
                    end
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rx_latch_r     <= BYTE_RESET;
            rx_ninth_bit_r <= 1'b0;
        end
        else if (rx_load)
        begin
            rx_latch_r     <= rx_shift_r[7:0];
            rx_ninth_bit_r <= rx_ninth;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_flag_sticky: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(rx_done_flag_r) |-> $past(wr_ctrl) && !$past(req.wdata[BIT_RXDONE]))
        else $error("receive flag cleared without software write");
    a_tx_flag_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        tx_done_set |=> tx_done_flag_r && tx_pin)
        else $error("transmit flag not set at stop bit");
    a_load_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        rx_load |-> !rx_done_flag_r)
        else $error("load while receive flag set");
    a_latch_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        !$past(rx_load) && !$past(sys_rst) |-> $stable(rx_latch_r) && $stable(rx_ninth_bit_r))
        else $error("receive latch changed without load");
    a_irq_flags: assert property (@(posedge core_clk) disable iff (sys_rst)
        irq == (irq_enable && (tx_done_flag_r || rx_done_flag_r)))
        else $error("interrupt not tied to flags");
    a_rx_disabled: assert property (@(posedge core_clk) disable iff (sys_rst)
        !ctrl_r.rx_en && rx_state_r == RX_IDLE |=> rx_state_r == RX_IDLE)
        else $error("receiver started while disabled");
    a_tx_start_low: assert property (@(posedge core_clk) disable iff (sys_rst)
        tx_state_r == TX_START && tx_bit_tick |=> !tx_pin)
        else $error("start bit not low");
    a_rx_reload: assert property (@(posedge core_clk) disable iff (sys_rst)
        rx_reload |=> rx_timer_r == $past(aux_timer_reload_byte_r))
        else $error("receive timer not reloaded on start");
    a_mpe_filter: assert property (@(posedge core_clk) disable iff (sys_rst)
        rx_load && ctrl_r.mpe |-> rx_ninth)
        else $error("filtered frame loaded");
    c_tx_frame: cover property (@(posedge core_clk) tx_done_set);
    c_rx_load9: cover property (@(posedge core_clk) rx_load && ctrl_r.mode9);
    c_overrun:  cover property (@(posedge core_clk) rx_state_r == RX_BITS && rx_done_flag_r);

endmodule // serial_port_zero

// *** far_uart_model.sv ***
// Far-side serial transceiver facing the port's pins
`timescale 1ns/100ps
module far_uart_model
#(
    parameter int BIT_CYC = 32
)
(
    // Clock
    input  wire logic       core_clk,
    // Serial pins
    input  wire logic       tx_pin,
    output logic            rx_pin,
    // Last frame seen on the port's output
    output logic [9:0]      cap_bits,
    output int              cap_count
);
    initial
    begin
        rx_pin    = 1'b1;
        cap_bits  = '0;
        cap_count = 0;
    end

    // ****
    // Receiver: mid-bit sampling of ten bits after the start bit
    // ****
    always
    begin
        @(negedge tx_pin);
        repeat (BIT_CYC / 2) @(posedge core_clk);
        if (tx_pin === 1'b0)
        begin
            for (int i = 0; i < 10; i++)
            begin
                repeat (BIT_CYC) @(posedge core_clk);
                cap_bits[i] = tx_pin;
            end
            cap_count++;
        end
    end

    // ****
    // Transmitter: one frame, line back to idle high afterwards
    // ****
    task automatic send(input logic [7:0] d, input logic nine, input logic b9, input logic stp);
        logic [10:0] f;
        f = nine ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            @(posedge core_clk);
            rx_pin <= f[i];
            repeat (BIT_CYC - 1) @(posedge core_clk);
        end
        @(posedge core_clk);
        rx_pin <= 1'b1;
    endtask
endmodule // far_uart_model

// *** testbench.sv ***
// Self-checking testbench for the timer-driven serial port
`timescale 1ns/100ps
module testbench;
    import serial_port_pkg::*;

    logic       core_clk;
    logic       sys_rst;
    reg_req_t   req;
    logic [7:0] rdata;
    logic       timer_run;
    logic [2:0] timer_src;
    logic       irq_enable;
    logic       rx_pin;
    logic       tx_pin;
    logic       irq;
    logic       osc_drv;
    logic       xin_drv;
    logic [9:0] cap_bits;
    int         cap_count;
    int         err_total;
    int         check_count;

    serial_port_zero uut (
        .core_clk(core_clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
        .timer_run(timer_run), .timer_src(timer_src), .ext_osc_clk(osc_drv),
        .aux_timer_ext_input(xin_drv), .irq_enable(irq_enable),
        .rx_pin(rx_pin), .tx_pin(tx_pin), .irq(irq));

    // Reload F0 with an undivided timer clock gives 32 cycles a bit
    far_uart_model #(.BIT_CYC(32)) far (
        .core_clk(core_clk), .tx_pin(tx_pin), .rx_pin(rx_pin),
        .cap_bits(cap_bits), .cap_count(cap_count));

    // ****
    // Bus and compare tasks
    // ****
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd_val(input logic [1:0] a, output logic [7:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        @(negedge core_clk);
        d = rdata;
    endtask

    task automatic rc(input string what, input logic [7:0] exp, input logic [1:0] a);
        logic [7:0] d;
        rd_val(a, d);
        chk(what, exp, d);
    endtask

    // Bounded wait for the far side to capture the frame
    task automatic tx_frame(input logic [7:0] d);
        int c;
        c = cap_count;
        wr(ADDR_DATA, d);
        for (int i = 0; i < 1000 && cap_count == c; i++)
            @(posedge core_clk);
        chk("tx frame seen", 8'h01, 8'(cap_count - c));
        // Let the stop bit finish; a data write while busy is ignored
        repeat (32) @(posedge core_clk);
    endtask

    task automatic rx_frame(input logic [7:0] d, input logic nine, input logic b9, input logic s);
        far.send(d, nine, b9, s);
        repeat (8) @(posedge core_clk);
    endtask

    // ****
    // Scenarios
    // ****
    task automatic t_tx8();
        wr(ADDR_CONTROL, 8'h00);
        tx_frame(8'hA5);
        chk("tx data", 8'hA5, cap_bits[7:0]);
        chk("tx stop", 8'h01, {7'h0, cap_bits[8]});
        rc("tx flag", 8'h42, ADDR_CONTROL);
        rc("no readback", 8'h00, ADDR_DATA);
        chk("irq on", 8'h01, {7'h0, irq});
        @(posedge core_clk);
        irq_enable <= 1'b0;
        @(negedge core_clk);
        chk("irq masked", 8'h00, {7'h0, irq});
        @(posedge core_clk);
        irq_enable <= 1'b1;
        wr(ADDR_CONTROL, 8'h00);
        rc("flag clear", 8'h40, ADDR_CONTROL);
        $display("test tx8 done");
    endtask

    task automatic t_tx9();
        wr(ADDR_CONTROL, 8'h88);
        tx_frame(8'h3C);
        chk("tx9 data", 8'h3C, cap_bits[7:0]);
        chk("tx9 ninth", 8'h01, {7'h0, cap_bits[8]});
        chk("tx9 stop", 8'h01, {7'h0, cap_bits[9]});
        wr(ADDR_CONTROL, 8'h80);
        tx_frame(8'hC3);
        chk("tx9 ninth0", 8'h00, {7'h0, cap_bits[8]});
        chk("tx9 flag", 8'h01, {7'h0, irq});
        $display("test tx9 done");
    endtask

    task automatic t_rx8();
        wr(ADDR_CONTROL, 8'h30);
        rx_frame(8'h5A, 1'b0, 1'b0, 1'b0);
        rc("bad stop", 8'h70, ADDR_CONTROL);
        rx_frame(8'h5A, 1'b0, 1'b0, 1'b1);
        rc("rx8 ctrl", 8'h75, ADDR_CONTROL);
        rc("rx8 data", 8'h5A, ADDR_DATA);
        rx_frame(8'hFF, 1'b0, 1'b0, 1'b1);
        rc("overrun", 8'h5A, ADDR_DATA);
        $display("test rx8 done");
    endtask

    task automatic t_rx9();
        wr(ADDR_CONTROL, 8'hB0);
        rx_frame(8'h22, 1'b1, 1'b0, 1'b1);
        rc("mp filter", 8'hF4, ADDR_CONTROL);
        rc("mp data", 8'h5A, ADDR_DATA);
        rx_frame(8'h11, 1'b1, 1'b1, 1'b0);
        rc("rx9 ctrl", 8'hF5, ADDR_CONTROL);
        rc("rx9 data", 8'h11, ADDR_DATA);
        wr(ADDR_CONTROL, 8'h90);
        rx_frame(8'h66, 1'b1, 1'b0, 1'b1);
        rc("ninth zero", 8'hD1, ADDR_CONTROL);
        rc("nomp data", 8'h66, ADDR_DATA);
        wr(ADDR_CONTROL, 8'h00);
        rx_frame(8'h77, 1'b0, 1'b0, 1'b1);
        rc("rx off", 8'h40, ADDR_CONTROL);
        rc("rx off data", 8'h66, ADDR_DATA);
        $display("test rx9 done");
    endtask

    // Timer advance over exactly 48 cycles, with pulses on both external inputs
    task automatic t_rate(input string what, input logic [2:0] src, input logic run,
                          input logic [7:0] exp);
        logic [7:0] v0;
        logic [7:0] v1;
        @(posedge core_clk);
        timer_src <= src;
        timer_run <= run;
        wr(ADDR_TIMER, 8'h00);
        rd_val(ADDR_TIMER, v0);
        for (int i = 0; i < 46; i++)
        begin
            @(posedge core_clk);
            xin_drv <= (i >= 4 && i < 36) && i[2];
            osc_drv <= (i >= 4 && i < 36) && i[1];
        end
        rd_val(ADDR_TIMER, v1);
        chk(what, exp, v1 - v0);
    endtask

    task automatic t_timer();
        t_rate("rate sys", SRC_SYS, 1'b1, 8'h30);
        t_rate("rate div4", SRC_DIV4, 1'b1, 8'h0C);
        t_rate("rate div12", SRC_DIV12, 1'b1, 8'h04);
        t_rate("rate div48", SRC_DIV48, 1'b1, 8'h01);
        t_rate("rate osc", SRC_EXT_OSC, 1'b1, 8'h01);
        t_rate("rate pin", SRC_EXT_PIN, 1'b1, 8'h04);
        t_rate("rate stopped", SRC_SYS, 1'b0, 8'h00);
        $display("test timer done");
    endtask

    // ****
    // Clock, watchdog, verdict, main sequence
    // ****
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    initial
    begin
        #200000;
        err_total++;
        report_and_stop();
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        sys_rst     = 1'b1;
        req         = '0;
        timer_run   = 1'b1;
        timer_src   = SRC_SYS;
        irq_enable  = 1'b1;
        osc_drv     = 1'b0;
        xin_drv     = 1'b0;
        err_total   = 0;
        check_count = 0;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        rc("reset ctrl", 8'h40, ADDR_CONTROL);
        rc("reset data", 8'h00, ADDR_DATA);
        wr(ADDR_RELOAD, 8'hF0);
        wr(ADDR_TIMER, 8'hF0);
        t_tx8();
        t_tx9();
        t_rx8();
        t_rx9();
        t_timer();
        report_and_stop();
    end
endmodule // testbench
